// ==== fwg_pkg.sv ====
`default_nettype none
package fwg_pkg;
  localparam logic [7:0] FWG_OFF_PSC = 8'h00;
  localparam logic [7:0] FWG_OFF_KEY = 8'h04;
  localparam logic [7:0] FWG_OFF_RSRC = 8'h08;
  localparam int FWG_PSC_WREN_BIT = 0;
  localparam int FWG_PSC_ERASE_BIT = 1;
  localparam int FWG_RSRC_SWRST_BIT = 4;
  localparam int FWG_RSRC_FERR_BIT = 6;
  localparam int FWG_KEY_OPEN_BIT = 0;
  localparam int FWG_KEY_DEAD_BIT = 1;
  localparam logic [7:0] FWG_KEY_FIRST = 8'ha5;
  localparam logic [7:0] FWG_KEY_SECOND = 8'hf1;
  localparam logic [7:0] FWG_ERASED = 8'hff;
  localparam logic [1:0] FWG_PSC_RESET = 2'h0;
  localparam logic [15:0] FWG_BOOT_ADDR = 16'h0000;
  localparam int FWG_PAGE_BYTES = 512;
  localparam int FWG_PAGE_AW = 9;
  localparam int FWG_CLK_MHZ = 250;
  localparam real FWG_RESET_DELAY_US = 5.0;
  localparam int FWG_RESET_CYCLES = int'($ceil(FWG_RESET_DELAY_US * FWG_CLK_MHZ));
  localparam real FWG_PROG_TIME_US = 40.0;
  localparam int FWG_PROG_CYCLES = int'($ceil(FWG_PROG_TIME_US * FWG_CLK_MHZ));
  localparam real FWG_ERASE_TIME_US = 20000.0;
  localparam int FWG_ERASE_CYCLES = int'($ceil(FWG_ERASE_TIME_US * FWG_CLK_MHZ));
  typedef enum logic [1:0] {lk_locked, lk_first, lk_open, lk_dead} fwg_lock_t;
  typedef enum logic [1:0] {op_idle, op_prog, op_erase_wait, op_erase_walk} fwg_op_t;
endpackage
`default_nettype wire

// ==== fwg_top.sv ====
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// How it works
// (R1) Data moves read and write program flash
// (R2) Redirected write above limit forces reset
// (R3) Code byte read above limit forces reset
// (R4) Fetch above limit forces reset
// (R5) Limit is 0x1DFF, 0x0FFF or 0x07FF
// (R6) Flash error reset sets source bit 6
// (R7) Writing source bit 4 forces reset
// (R8) Software reset never drives reset pin
// (R9) Hold core 5.0 us after reset
// (R10) Writes only clear bits; erase gives 0xFF
// (R11) Operations self timed, core stalled meanwhile
// (R12) Reads free; writes need unlock first
// (R13) Software writes 0xA5 then 0xF1
// (R14) Wrong keys block flash until reset
// (R15) Early write attempt blocks until reset
// (R16) Lock closes again after each operation
// (R17) Redirect enable bit 0 stays until cleared
// (R18) Erase enable plus redirect erases 512-byte page
// (R19) Software should mask interrupts before erase
// (R20) Without erase enable, one byte programmed
module fwg_top #(
  parameter logic [15:0] USER_LIMIT = 16'h1dff,
  parameter int FLASH_BYTES = 8192,
  parameter int PROG_CYCLES = fwg_pkg::FWG_PROG_CYCLES,
  parameter int ERASE_CYCLES = fwg_pkg::FWG_ERASE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dm_req,
  input wire logic dm_write,
  input wire logic [15:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  input wire logic code_read_req,
  input wire logic [15:0] code_read_addr,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic [7:0] core_rdata,
  output logic core_stall,
  output logic core_reset_n,
  output logic [15:0] core_boot_addr,
  output logic rst_pin_oe_n
);
  import fwg_pkg::*;

  localparam int AW = $clog2(FLASH_BYTES);
  localparam int PW = AW - FWG_PAGE_AW;

  initial begin
    if (USER_LIMIT != 16'h1dff && USER_LIMIT != 16'h0fff && USER_LIMIT != 16'h07ff) begin // R5
      $error("USER_LIMIT must be one of the three variant limits");
    end
    if (FLASH_BYTES <= int'(USER_LIMIT) || FLASH_BYTES > 65536 || PROG_CYCLES < 1
        || ERASE_CYCLES < 1 || PW < 1) begin
      $error("flash size or timing parameters out of range");
    end
  end

  logic [7:0] mem [0:FLASH_BYTES-1];

  logic [1:0] psc_reg, psc_next;
  fwg_lock_t lock_reg, lock_next;
  fwg_op_t op_reg, op_next;
  logic [31:0] tmr_reg, tmr_next;
  logic [AW-1:0] waddr_reg, waddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic [FWG_PAGE_AW-1:0] walk_reg, walk_next;
  logic [1:0] rsrc_reg, rsrc_next;
  logic [10:0] hold_reg, hold_next;
  logic core_reset_n_reg, core_reset_n_next;
  logic core_stall_reg, core_stall_next;
  logic [7:0] core_rdata_reg, core_rdata_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic apb_wr, key_wr, sw_rst, flash_err, flash_attempt, any_rst, run;

  function automatic logic above_limit(input logic [15:0] a);
    return a > USER_LIMIT;
  endfunction

  assign run = core_reset_n_reg;
  assign apb_wr = psel && penable && pready_reg && pwrite;
  assign key_wr = apb_wr && paddr == FWG_OFF_KEY;
  assign sw_rst = apb_wr && paddr == FWG_OFF_RSRC && pwdata[FWG_RSRC_SWRST_BIT]; // R7
  assign flash_attempt = run && dm_req && dm_write && psc_reg[FWG_PSC_WREN_BIT]; // R17
  assign flash_err = run && ((flash_attempt && above_limit(dm_addr)) // R2
    || (code_read_req && above_limit(code_read_addr)) // R3
    || (fetch_req && above_limit(fetch_addr))); // R4
  assign any_rst = sw_rst || flash_err;

  // APB slave: no wait states, though every answer comes from a flop.
  always_comb begin
    pready_next = psel && !penable;
    pslverr_next = 1'b0;
    prdata_next = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        FWG_OFF_PSC: prdata_next = {30'h0, psc_reg};
        FWG_OFF_KEY: begin
          prdata_next[FWG_KEY_OPEN_BIT] = lock_reg == lk_open;
          prdata_next[FWG_KEY_DEAD_BIT] = lock_reg == lk_dead;
        end
        FWG_OFF_RSRC: begin
          prdata_next[FWG_RSRC_SWRST_BIT] = rsrc_reg[0];
          prdata_next[FWG_RSRC_FERR_BIT] = rsrc_reg[1];
        end
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  // Lock, control and operation sequencing.
  always_comb begin
    psc_next = psc_reg;
    lock_next = lock_reg;
    op_next = op_reg;
    tmr_next = tmr_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    walk_next = walk_reg;
    mem_we = 1'b0;
    mem_waddr = waddr_reg;
    mem_wdata = wdata_reg;
    if (apb_wr && paddr == FWG_OFF_PSC) begin
      psc_next = pwdata[1:0]; // R17
    end
    if (key_wr) begin
      unique case (lock_reg)
        lk_locked: lock_next = pwdata[7:0] == FWG_KEY_FIRST ? lk_first : lk_dead; // R14
        lk_first: lock_next = pwdata[7:0] == FWG_KEY_SECOND ? lk_open : lk_dead; // R12 R14
        lk_open: lock_next = lk_dead;
        lk_dead: lock_next = lk_dead;
      endcase
    end
    if (flash_attempt && !above_limit(dm_addr) && op_reg == op_idle) begin
      if (lock_reg != lk_open) begin
        lock_next = lk_dead; // R15
      end else begin
        lock_next = lk_locked; // R16
        waddr_next = dm_addr[AW-1:0];
        tmr_next = 32'(psc_reg[FWG_PSC_ERASE_BIT] ? ERASE_CYCLES : PROG_CYCLES); // R11
        wdata_next = mem[dm_addr[AW-1:0]] & dm_wdata; // R10 R20
        op_next = psc_reg[FWG_PSC_ERASE_BIT] ? op_erase_wait : op_prog; // R18
      end
    end
    unique case (op_reg)
      op_idle: ;
      op_prog: begin
        tmr_next = tmr_reg - 32'h1;
        if (tmr_reg == 32'h1) begin
          mem_we = 1'b1; // R20
          op_next = op_idle;
        end
      end
      op_erase_wait: begin
        tmr_next = tmr_reg - 32'h1;
        walk_next = '0;
        if (tmr_reg == 32'h1) begin
          op_next = op_erase_walk;
        end
      end
      op_erase_walk: begin
        mem_we = 1'b1;
        mem_waddr = {waddr_reg[AW-1:FWG_PAGE_AW], walk_reg}; // R18
        mem_wdata = FWG_ERASED; // R10
        walk_next = walk_reg + FWG_PAGE_AW'(1);
        if (walk_reg == FWG_PAGE_AW'(FWG_PAGE_BYTES - 1)) begin
          op_next = op_idle;
        end
      end
    endcase
    if (any_rst) begin
      psc_next = FWG_PSC_RESET;
      lock_next = lk_locked;
      op_next = op_idle;
      mem_we = 1'b0;
    end
  end

  // Reset source, hold-off timer and core-facing outputs.
  always_comb begin
    rsrc_next = rsrc_reg;
    hold_next = hold_reg;
    core_reset_n_next = core_reset_n_reg;
    core_rdata_next = core_rdata_reg;
    core_stall_next = op_next != op_idle; // R11
    if (!core_reset_n_reg) begin
      hold_next = hold_reg - 11'h1;
      if (hold_reg == 11'h1) begin
        core_reset_n_next = 1'b1; // R9
      end
    end
    if (run && code_read_req) begin
      core_rdata_next = mem[code_read_addr[AW-1:0]]; // R12
    end else if (run && dm_req && !dm_write) begin
      core_rdata_next = mem[dm_addr[AW-1:0]]; // R1
    end
    if (any_rst) begin
      rsrc_next = {flash_err, sw_rst && !flash_err}; // R6 R7
      hold_next = 11'(FWG_RESET_CYCLES);
      core_reset_n_next = 1'b0;
      core_stall_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_reg <= FWG_PSC_RESET;
      lock_reg <= lk_locked;
      op_reg <= op_idle;
      tmr_reg <= 32'h0;
      waddr_reg <= '0;
      wdata_reg <= 8'h00;
      walk_reg <= '0;
      rsrc_reg <= 2'h0;
      hold_reg <= 11'(FWG_RESET_CYCLES);
      core_reset_n_reg <= 1'b0;
      core_stall_reg <= 1'b0;
      core_rdata_reg <= 8'h00;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      psc_reg <= psc_next;
      lock_reg <= lock_next;
      op_reg <= op_next;
      tmr_reg <= tmr_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      walk_reg <= walk_next;
      rsrc_reg <= rsrc_next;
      hold_reg <= hold_next;
      core_reset_n_reg <= core_reset_n_next;
      core_stall_reg <= core_stall_next;
      core_rdata_reg <= core_rdata_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Flash contents survive every reset, as non-volatile storage must.
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign core_rdata = core_rdata_reg;
  assign core_stall = core_stall_reg;
  assign core_reset_n = core_reset_n_reg;

  // Boot vector and reset pin enable are constants held in flops.
  logic [15:0] boot_reg;
  logic pin_oe_n_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= FWG_BOOT_ADDR;
      pin_oe_n_reg <= 1'b1;
    end else begin
      boot_reg <= FWG_BOOT_ADDR; // R9
      pin_oe_n_reg <= 1'b1; // R8
    end
  end
  assign core_boot_addr = boot_reg;
  assign rst_pin_oe_n = pin_oe_n_reg;

  sequence seq_key(logic [7:0] k);
    key_wr && pwdata[7:0] == k;
  endsequence
  sequence seq_start;
    flash_attempt && !above_limit(dm_addr) && op_reg == op_idle && !any_rst;
  endsequence

  // Keys may be any distance apart, so each step is checked on its own edge.
  chk_key_unlock: assert property (@(posedge pclk) disable iff (!presetn) // R12
    ((lock_reg == lk_locked && !flash_attempt && !any_rst) ##0 seq_key(FWG_KEY_FIRST)
    |=> lock_reg == lk_first)
    and ((lock_reg == lk_first && !flash_attempt && !any_rst) ##0 seq_key(FWG_KEY_SECOND)
    |=> lock_reg == lk_open)) else $error("two keys in order did not unlock");
  chk_bad_key: assert property (@(posedge pclk) disable iff (!presetn) // R14
    (lock_reg == lk_first && !any_rst) ##0 seq_key(8'h00) |=> lock_reg == lk_dead [*2])
    else $error("wrong second key did not block flash");
  chk_early_try: assert property (@(posedge pclk) disable iff (!presetn) // R15
    seq_start and (lock_reg == lk_locked) |=> lock_reg == lk_dead && op_reg == op_idle)
    else $error("write before unlock was not blocked");
  chk_relock_op: assert property (@(posedge pclk) disable iff (!presetn) // R16
    seq_start and (lock_reg == lk_open) |=> lock_reg == lk_locked && core_stall_reg) // R11
    else $error("lock not closed or core not stalled at start");
  chk_range_rst: assert property (@(posedge pclk) disable iff (!presetn) // R2
    flash_attempt && above_limit(dm_addr) |=> !core_reset_n_reg && rsrc_reg == 2'h2) // R6
    else $error("out of range write did not raise flash error reset");
  chk_fetch_rst: assert property (@(posedge pclk) disable iff (!presetn) // R4
    run && (fetch_req && above_limit(fetch_addr) || code_read_req // R3
    && above_limit(code_read_addr)) |=> !core_reset_n_reg && rsrc_reg[1])
    else $error("illegal code access did not reset");
  chk_sw_reset: assert property (@(posedge pclk) disable iff (!presetn) // R7
    sw_rst && !flash_err |=> rsrc_reg == 2'h1 && !core_reset_n_reg && rst_pin_oe_n) // R8
    else $error("software reset not taken or drove the pin");
  chk_reset_hold: assert property (@(posedge pclk) disable iff (!presetn) // R9
    $fell(core_reset_n_reg) |-> !core_reset_n_reg [*8] ##1 hold_reg == 11'(FWG_RESET_CYCLES - 8))
    else $error("core released too early after reset");
  chk_erase_ff: assert property (@(posedge pclk) disable iff (!presetn) // R18
    op_reg == op_erase_walk && !any_rst |-> mem_we && mem_wdata == FWG_ERASED) // R10
    else $error("erase walk did not write erased value");
endmodule
`default_nettype wire

// ==== fwg_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fwg_core_model (
  input wire logic pclk,
  output logic dm_req,
  output logic dm_write,
  output logic [15:0] dm_addr,
  output logic [7:0] dm_wdata,
  output logic code_read_req,
  output logic [15:0] code_read_addr,
  output logic fetch_req,
  output logic [15:0] fetch_addr,
  input wire logic [7:0] core_rdata,
  input wire logic core_stall
);
  initial begin
    {dm_req, dm_write, code_read_req, fetch_req} = 4'h0;
    {dm_addr, code_read_addr, fetch_addr} = 48'h0;
    dm_wdata = 8'h00;
  end
  // Kind 0 is a data move, 1 a code byte read, 2 a branch target fetch.
  task automatic issue(input int kind, input logic wr, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] rd, output logic st);
    @(posedge pclk);
    dm_req <= (kind == 0);
    code_read_req <= (kind == 1);
    fetch_req <= (kind == 2);
    dm_write <= wr;
    dm_addr <= a;
    dm_wdata <= d;
    code_read_addr <= a;
    fetch_addr <= a;
    @(posedge pclk);
    {dm_req, code_read_req, fetch_req} <= 3'h0;
    // Released lines show the inverse so a stale address can never pass for a live one.
    dm_addr <= ~a;
    dm_wdata <= ~d;
    code_read_addr <= ~a;
    fetch_addr <= ~a;
    @(posedge pclk);
    rd = core_rdata;
    st = core_stall;
  endtask
endmodule
`default_nettype wire

// ==== fwg_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module fwg_top_tb_top;
  import fwg_pkg::*;
  localparam int PROG = 20;
  localparam int ERASE = 30;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} fwg_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, dm_req, dm_write, code_read_req, fetch_req;
  logic core_stall, core_reset_n, rst_pin_oe_n, st, er;
  logic [15:0] dm_addr, code_read_addr, fetch_addr, core_boot_addr;
  logic [7:0] dm_wdata, core_rdata, rd;
  int fails = 0;
  int total_checks = 0;
  int n;
  fwg_row_t rows [9] = '{
    '{1'b0, FWG_OFF_PSC, 32'h0, {30'h0, FWG_PSC_RESET}, 1'b0},
    '{1'b1, FWG_OFF_PSC, 32'h1, 32'h0, 1'b0},
    '{1'b0, FWG_OFF_PSC, 32'h0, 32'h1, 1'b0},
    '{1'b1, FWG_OFF_PSC, 32'h3, 32'h0, 1'b0},
    '{1'b0, FWG_OFF_PSC, 32'h0, 32'h3, 1'b0},
    '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h0c, 32'h5, 32'h0, 1'b1},
    '{1'b0, FWG_OFF_RSRC, 32'h0, 32'h0, 1'b0},
    '{1'b0, FWG_OFF_KEY, 32'h0, 32'h0, 1'b0}};
  always #2 pclk = ~pclk;
  fwg_top #(.PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE)) fwg_top_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dm_req, .dm_write,
    .dm_addr, .dm_wdata, .code_read_req, .code_read_addr, .fetch_req, .fetch_addr,
    .core_rdata, .core_stall, .core_reset_n, .core_boot_addr, .rst_pin_oe_n);
  fwg_core_model fwg_core_model_i (.pclk, .dm_req, .dm_write, .dm_addr, .dm_wdata,
    .code_read_req, .code_read_addr, .fetch_req, .fetch_addr, .core_rdata, .core_stall);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      fails++;
      give_verdict();
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ready(input int lim);
    for (n = 0; n < lim; n++) begin
      if (core_reset_n === 1'b1 && core_stall === 1'b0) break;
      @(posedge pclk);
    end
    if (n == lim) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic wait_reset();
    int i;
    for (i = 0; i < 10 && core_reset_n !== 1'b0; i++) begin
      @(posedge pclk);
    end
    chk({31'h0, core_reset_n}, 32'h0);
    wait_ready(2000);
  endtask
  task automatic unlock();
    apb(1'b1, FWG_OFF_KEY, {24'h0, FWG_KEY_FIRST});
    apb(1'b1, FWG_OFF_KEY, {24'h0, FWG_KEY_SECOND});
  endtask
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    unlock();
    apb(1'b0, FWG_OFF_KEY, 32'h0);
    chk(rv, 32'h1);
    fwg_core_model_i.issue(0, 1'b1, a, d, rd, st);
    chk({31'h0, st}, 32'h1);
    wait_ready(ERASE + 1000);
    apb(1'b0, FWG_OFF_KEY, 32'h0);
    chk(rv, 32'h0);
  endtask
  task automatic crd(input logic [15:0] a, input logic [7:0] exp);
    fwg_core_model_i.issue(1, 1'b0, a, 8'h00, rd, st);
    chk({24'h0, rd}, {24'h0, exp});
  endtask
  // The reset pin must never be driven, whatever reset is in progress.
  always @(posedge pclk) begin
    if (presetn) chk({31'h0, rst_pin_oe_n}, 32'h1);
  end
  initial begin
    #400000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wait_ready(2000);
    chk(32'(n >= 1250), 32'h1);
    chk({16'h0, core_boot_addr}, {16'h0, FWG_BOOT_ADDR});
    foreach (rows[k]) begin
      apb(rows[k].wr, rows[k].a, rows[k].d);
      chk({31'h0, er}, {31'h0, rows[k].err});
      if (!rows[k].wr) chk(rv, rows[k].exp);
    end
    prog(16'h0010, 8'h00);
    crd(16'h0000, FWG_ERASED);
    crd(16'h01ff, FWG_ERASED);
    crd(16'h0010, FWG_ERASED);
    prog(16'h1dff, 8'h00);
    apb(1'b1, FWG_OFF_PSC, 32'h1);
    prog(16'h0005, 8'h3c);
    prog(16'h0005, 8'hf0);
    crd(16'h0005, 8'h30);
    crd(16'h0004, FWG_ERASED);
    fwg_core_model_i.issue(0, 1'b0, 16'h0005, 8'h00, rd, st);
    chk({24'h0, rd}, 32'h30);
    fwg_core_model_i.issue(0, 1'b1, 16'h0006, 8'h00, rd, st);
    chk({31'h0, st}, 32'h0);
    unlock();
    apb(1'b0, FWG_OFF_KEY, 32'h0);
    chk(rv, 32'h2);
    fwg_core_model_i.issue(0, 1'b1, 16'h0006, 8'h00, rd, st);
    chk({31'h0, st}, 32'h0);
    crd(16'h0006, FWG_ERASED);
    apb(1'b1, FWG_OFF_RSRC, 32'h10);
    wait_reset();
    apb(1'b0, FWG_OFF_RSRC, 32'h0);
    chk(rv, 32'h10);
    apb(1'b0, FWG_OFF_PSC, 32'h0);
    chk(rv, 32'h0);
    apb(1'b1, FWG_OFF_KEY, 32'h5a);
    apb(1'b0, FWG_OFF_KEY, 32'h0);
    chk(rv, 32'h2);
    crd(16'h1dff, FWG_ERASED);
    chk({31'h0, core_reset_n}, 32'h1);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, FWG_OFF_PSC, 32'h1);
      fwg_core_model_i.issue(k, 1'b1, 16'h1e00, 8'h00, rd, st);
      wait_reset();
      apb(1'b0, FWG_OFF_RSRC, 32'h0);
      chk(rv, 32'h40);
    end
    apb(1'b1, FWG_OFF_KEY, {24'h0, FWG_KEY_FIRST});
    apb(1'b1, FWG_OFF_KEY, 32'h0);
    apb(1'b0, FWG_OFF_KEY, 32'h0);
    chk(rv, 32'h2);
    give_verdict();
  end
endmodule
`default_nettype wire
